// >>> logic/irptm_consts.svh
// Register offsets, field positions, reset values and timing figures of the IR modulator
`ifndef IRPTM_CONSTS_SVH
`define IRPTM_CONSTS_SVH

`define IRPTM_OFF_CNT_LO    4'h6
`define IRPTM_OFF_CNT_HI    4'h7
`define IRPTM_OFF_CCTL      4'h8
`define IRPTM_OFF_ACT_TIME  4'h9
`define IRPTM_OFF_INACT_TIME 4'hA
`define IRPTM_OFF_CTRL      4'hD
`define IRPTM_OFF_STATUS    4'hE

`define IRPTM_BIT_PWM       0
`define IRPTM_BIT_LONG      1
`define IRPTM_BIT_GATE      2
`define IRPTM_BIT_ENA       3
`define IRPTM_BIT_MF_LO     4
`define IRPTM_BIT_HBE       4

`define IRPTM_RST_BYTE      8'h00
`define IRPTM_CLK_PERIOD_NS 5
`define IRPTM_TIMER_STEP    8'h01
`define IRPTM_COUNT_STEP    16'h0001

`endif

// >>> logic/irptm_pkg.sv
// Types shared by the IR pulse train modulator
package irptm_pkg;
   typedef enum logic [1:0] {
      IRPTM_IDLE   = 2'b00,
      IRPTM_ACTIVE = 2'b01,
      IRPTM_GAP    = 2'b10,
      IRPTM_DONE   = 2'b11
   } irptm_phase_t;
endpackage

// >>> logic/irptm_carrier.sv
// Carrier divider that produces the modulation square wave
`timescale 1ns/100ps
`default_nettype none
module irptm_carrier
   import irptm_pkg::*;
(
   input  wire logic       ref_clk_in,   // System clock
   input  wire logic       rst_n_in,     // Sync reset, active low
   input  wire logic       run_in,       // Carrier runs while high
   input  wire logic [1:0] sel_in,       // Divider select
   output logic            carrier_out   // Carrier level, registered
);
   typedef struct packed {
      logic [2:0] div;
      logic       lvl;
   } irptm_car_t;

   irptm_car_t st_reg;
   irptm_car_t st_next;

   // Half period length; select 01 is undefined and treated like 00, a one-clock half period
   function automatic logic [2:0] irptm_half(input logic [1:0] s);
      case (s)
         2'b10:   irptm_half = 3'h1;
         2'b11:   irptm_half = 3'h3;
         default: irptm_half = 3'h0;
      endcase
   endfunction

   // Divider toggles the level each half period
   always_comb begin
      st_next = st_reg;
      if (!run_in) begin
         st_next.div = 3'h0;
         st_next.lvl = 1'b0;
      end else if (st_reg.div >= irptm_half(sel_in)) begin
         st_next.div = 3'h0;
         st_next.lvl = ~st_reg.lvl;
      end else begin
         st_next.div = st_reg.div + 3'h1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign carrier_out = st_reg.lvl;
endmodule
`default_nettype wire

// >>> logic/irptm_top.sv
// IR pulse train modulator with its register port
// Operation
// RULE_01 - Eight-bit active time register
// RULE_02 - Active time equals value in clocks
// RULE_03 - Eight-bit inactive time register
// RULE_04 - Inactive time equals value in clocks
// RULE_05 - Timer reloads alternately, counts down by one
// RULE_06 - Software loads nonzero pulse count
// RULE_07 - Software never leaves time registers zero
// RULE_08 - Software configures control, times, then count
// RULE_09 - Registers at offsets 06, 07, 09, 0A
// RULE_10 - Low count write starts, drives output low
// RULE_11 - Timer loads active time at start
// RULE_12 - Active expiry decrements count, output high
// RULE_13 - Inactive expiry restarts active phase
// RULE_14 - Count zero sets flag, interrupt, stops
// RULE_15 - Software disables before clearing flag
// RULE_16 - Software retoggles enable for next burst
// RULE_17 - Carrier gate modulates active phase
// RULE_18 - Long pulse mode ignores inactive time
// RULE_19 - Continuous mode runs endlessly without counter
// RULE_20 - High byte counts only when enabled
// RULE_21 - Idle or finished keeps output high
// RULE_22 - Reset clears enable, options, flag
`timescale 1ns/100ps
`default_nettype none
`include "irptm_consts.svh"
module irptm_top
   import irptm_pkg::*;
(
   input  wire logic       ref_clk_in,   // 200 MHz oscillator clock
   input  wire logic       rst_n_in,     // Sync reset, active low
   input  wire logic       page1_in,     // Register page 1 selected
   input  wire logic [3:0] addr_in,      // Register address
   input  wire logic       wr_in,        // Write strobe, one cycle
   input  wire logic [7:0] wdata_in,     // Write data
   input  wire logic       flag_clr_in,  // Clear burst complete flag
   output logic [7:0]      rdata_out,    // Read data, registered
   output logic            ir_drive_out, // IR pin level, low active
   output logic            irq_out       // Burst complete request
);
   typedef struct packed {
      irptm_phase_t phase;
      logic [7:0]   act_time;
      logic [7:0]   inact_time;
      logic [7:0]   ctrl;
      logic         hbe;
      logic [15:0]  count;
      logic [7:0]   timer;
      logic         flag;
      logic         pin;
      logic [7:0]   rdata;
   } irptm_state_t;

   irptm_state_t st_reg;
   irptm_state_t st_next;
   logic         carrier;
   logic         enabled;
   logic         cnt_last;
   logic         timer_end;
   logic [15:0]  cnt_dec;

   // -------------------------------------------------------------
   // Address decode for the write paths; the read mux decodes addr_in directly
   // -------------------------------------------------------------
   function automatic logic irptm_hit(input logic [3:0] a, input logic [3:0] off,
                                      input logic pg, input logic need_pg);
      irptm_hit = (a == off) && (pg || !need_pg);
   endfunction

   assign enabled   = st_reg.ctrl[`IRPTM_BIT_ENA];
   assign timer_end = (st_reg.timer == `IRPTM_TIMER_STEP);
   assign cnt_dec   = st_reg.count - `IRPTM_COUNT_STEP;
   // Without the high byte enabled only the low byte matters
   assign cnt_last  = st_reg.hbe ? (st_reg.count == `IRPTM_COUNT_STEP)
                                 : (st_reg.count[7:0] == 8'h01); // [RULE_20]

   // -------------------------------------------------------------
   // Carrier runs only in the active phase so each pulse starts on a fresh edge
   // -------------------------------------------------------------
   irptm_carrier u_carrier (
      .ref_clk_in  (ref_clk_in),
      .rst_n_in    (rst_n_in),
      .run_in      (st_reg.phase == IRPTM_ACTIVE),
      .sel_in      (st_reg.ctrl[`IRPTM_BIT_MF_LO +: 2]),
      .carrier_out (carrier)
   );

   // -------------------------------------------------------------
   // Register port, sequencer and read mux
   // -------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      if (wr_in) begin
         if (irptm_hit(addr_in, `IRPTM_OFF_ACT_TIME, page1_in, 1'b1)) begin
            st_next.act_time = wdata_in; // [RULE_01] [RULE_09]
         end
         if (irptm_hit(addr_in, `IRPTM_OFF_INACT_TIME, page1_in, 1'b1)) begin
            st_next.inact_time = wdata_in; // [RULE_03] [RULE_09]
         end
         if (irptm_hit(addr_in, `IRPTM_OFF_CNT_HI, page1_in, 1'b1)) begin
            st_next.count[15:8] = wdata_in; // [RULE_09]
         end
         if (irptm_hit(addr_in, `IRPTM_OFF_CCTL, page1_in, 1'b0)) begin
            st_next.hbe = wdata_in[`IRPTM_BIT_HBE];
         end
         if (irptm_hit(addr_in, `IRPTM_OFF_CTRL, page1_in, 1'b0)) begin
            st_next.ctrl = wdata_in;
         end
      end
      // Sequencer
      case (st_reg.phase)
         IRPTM_IDLE: begin
            st_next.pin = 1'b1; // [RULE_21]
            if (wr_in && enabled && irptm_hit(addr_in, `IRPTM_OFF_CNT_LO, page1_in, 1'b1)) begin
               st_next.count[7:0] = wdata_in;
               st_next.phase = IRPTM_ACTIVE; // [RULE_10]
               st_next.pin = 1'b0; // [RULE_10]
               st_next.timer = st_reg.act_time; // [RULE_11]
            end else if (wr_in && irptm_hit(addr_in, `IRPTM_OFF_CNT_LO, page1_in, 1'b1)) begin
               st_next.count[7:0] = wdata_in;
            end
         end
         IRPTM_ACTIVE: begin
            st_next.timer = st_reg.timer - `IRPTM_TIMER_STEP; // [RULE_02] [RULE_05]
            if (timer_end) begin
               if (st_reg.ctrl[`IRPTM_BIT_LONG]) begin
                  // Long pulse: stay active, reload active time per count
                  st_next.timer = st_reg.act_time; // [RULE_18]
                  st_next.count = cnt_dec;
                  if (cnt_last) begin
                     st_next.phase = IRPTM_DONE; // [RULE_14]
                     st_next.flag = 1'b1;
                     st_next.pin = 1'b1;
                  end
               end else begin
                  st_next.pin = 1'b1; // [RULE_12]
                  st_next.timer = st_reg.inact_time; // [RULE_05]
                  if (!st_reg.ctrl[`IRPTM_BIT_PWM]) begin
                     st_next.count = cnt_dec; // [RULE_12]
                  end
                  if (!st_reg.ctrl[`IRPTM_BIT_PWM] && cnt_last) begin
                     st_next.phase = IRPTM_DONE; // [RULE_14]
                     st_next.flag = 1'b1; // [RULE_14]
                  end else begin
                     st_next.phase = IRPTM_GAP; // [RULE_19]
                  end
               end
            end
         end
         IRPTM_GAP: begin
            st_next.timer = st_reg.timer - `IRPTM_TIMER_STEP; // [RULE_04] [RULE_05]
            if (timer_end) begin
               st_next.phase = IRPTM_ACTIVE; // [RULE_13]
               st_next.pin = 1'b0; // [RULE_13]
               st_next.timer = st_reg.act_time; // [RULE_05]
            end
         end
         IRPTM_DONE: begin
            st_next.pin = 1'b1; // [RULE_21]
            st_next.timer = `IRPTM_RST_BYTE;
            if (!enabled) begin
               st_next.phase = IRPTM_IDLE;
            end
         end
         default: begin
            st_next.phase = IRPTM_IDLE;
         end
      endcase
      // Disable aborts any burst at once
      if (!st_next.ctrl[`IRPTM_BIT_ENA] && st_next.phase != IRPTM_DONE) begin
         st_next.phase = IRPTM_IDLE; // [RULE_21]
         st_next.pin = 1'b1;
         st_next.timer = `IRPTM_RST_BYTE;
      end
      // Flag clears only once the enable is off; a new set wins over the clear
      if (flag_clr_in && !enabled && !(st_next.flag && !st_reg.flag)) begin
         st_next.flag = 1'b0; // [RULE_15]
      end
      // Registered read data
      case (addr_in)
         `IRPTM_OFF_CNT_LO:     st_next.rdata = page1_in ? st_reg.count[7:0] : 8'h00;
         `IRPTM_OFF_CNT_HI:     st_next.rdata = page1_in ? st_reg.count[15:8] : 8'h00;
         `IRPTM_OFF_ACT_TIME:   st_next.rdata = page1_in ? st_reg.act_time : 8'h00;
         `IRPTM_OFF_INACT_TIME: st_next.rdata = page1_in ? st_reg.inact_time : 8'h00;
         `IRPTM_OFF_CCTL:       st_next.rdata = {3'h0, st_reg.hbe, 4'h0};
         `IRPTM_OFF_CTRL:       st_next.rdata = st_reg.ctrl;
         `IRPTM_OFF_STATUS:     st_next.rdata = {6'h00, st_reg.phase != IRPTM_IDLE, st_reg.flag};
         default:               st_next.rdata = 8'h00;
      endcase
   end

   // -------------------------------------------------------------
   // Single state register
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         st_reg       <= '0; // [RULE_22]
         st_reg.pin   <= 1'b1;
         st_reg.phase <= IRPTM_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // Carrier gates the low time: output low only when carrier is high
   assign ir_drive_out = (st_reg.phase == IRPTM_ACTIVE && st_reg.ctrl[`IRPTM_BIT_GATE])
                         ? ~carrier : st_reg.pin; // [RULE_17]
   assign irq_out   = st_reg.flag; // [RULE_14]
   assign rdata_out = st_reg.rdata;

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   AST_START_LOW: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_10]
      (st_reg.phase == IRPTM_IDLE && wr_in && enabled && page1_in
       && addr_in == `IRPTM_OFF_CNT_LO
       && st_reg.ctrl[`IRPTM_BIT_ENA] && st_next.ctrl[`IRPTM_BIT_ENA])
      |=> (st_reg.phase == IRPTM_ACTIVE && st_reg.pin == 1'b0))
      else $error("start did not drive the pin low");

   AST_LOAD_ACT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_11]
      ($rose(st_reg.phase == IRPTM_ACTIVE) && !$past(wr_in)) |-> st_reg.timer == st_reg.act_time)
      else $error("active phase did not load active time");

   AST_GAP_LOAD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_05]
      ($past(st_reg.phase) == IRPTM_ACTIVE && st_reg.phase == IRPTM_GAP && !$past(wr_in))
      |-> st_reg.timer == st_reg.inact_time)
      else $error("gap did not load inactive time");

   AST_DEC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_12]
      (st_reg.phase == IRPTM_ACTIVE && timer_end && !st_reg.ctrl[`IRPTM_BIT_LONG]
       && !st_reg.ctrl[`IRPTM_BIT_PWM] && !wr_in && enabled)
      |=> (st_reg.count == $past(cnt_dec) && st_reg.pin))
      else $error("count not decremented at active end");

   AST_DONE_FLAG: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_14]
      $rose(st_reg.phase == IRPTM_DONE) |-> st_reg.flag && irq_out)
      else $error("burst end without flag");

   AST_IDLE_HIGH: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_21]
      (st_reg.phase == IRPTM_IDLE || st_reg.phase == IRPTM_DONE) |-> ir_drive_out)
      else $error("pin active while idle");

   AST_FLAG_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_15]
      (st_reg.flag && enabled) |=> st_reg.flag)
      else $error("flag cleared while enabled");

   AST_PWM_NO_END: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_19]
      (st_reg.ctrl[`IRPTM_BIT_PWM] && !st_reg.ctrl[`IRPTM_BIT_LONG]
       && st_reg.phase == IRPTM_ACTIVE && !wr_in && enabled) |=> st_reg.phase != IRPTM_DONE)
      else $error("continuous train stopped");

   // Reset must leave nothing armed, whatever came before
   AST_RST_STATE: assert property (@(posedge ref_clk_in) // [RULE_22]
      !rst_n_in |=> (st_reg.ctrl == 8'h00 && !st_reg.flag && st_reg.pin
                     && st_reg.phase == IRPTM_IDLE))
      else $error("reset left the modulator armed");

   AST_TIMER_DEC: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_05]
      ((st_reg.phase == IRPTM_ACTIVE || st_reg.phase == IRPTM_GAP) && !timer_end
       && enabled && !wr_in)
      |=> st_reg.timer == $past(st_reg.timer) - `IRPTM_TIMER_STEP)
      else $error("pulse timer did not count down by one");

   AST_GAP_RESTART: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_13]
      (st_reg.phase == IRPTM_GAP && timer_end && enabled && !wr_in)
      |=> (st_reg.phase == IRPTM_ACTIVE && !st_reg.pin
           && st_reg.timer == st_reg.act_time))
      else $error("gap end did not restart the active phase");

   AST_LONG_HOLD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_18]
      (st_reg.phase == IRPTM_ACTIVE && st_reg.ctrl[`IRPTM_BIT_LONG]
       && !(timer_end && cnt_last) && enabled && !wr_in)
      |=> (st_reg.phase == IRPTM_ACTIVE && !st_reg.pin))
      else $error("long pulse broke before its end");

   // A finished burst ignores a new low count byte until the enable is cycled
   AST_CNT_KEEP: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_16]
      (st_reg.phase == IRPTM_DONE && wr_in && page1_in && addr_in == `IRPTM_OFF_CNT_LO)
      |=> (st_reg.count == $past(st_reg.count) && st_reg.phase != IRPTM_ACTIVE))
      else $error("finished burst took a new count");

   AST_NO_START: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_16]
      (st_reg.phase == IRPTM_IDLE && !enabled) |=> st_reg.phase == IRPTM_IDLE)
      else $error("modulator started while disabled");

   AST_FLAG_CLEAR: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [RULE_15]
      (st_reg.flag && !enabled && flag_clr_in) |=> !st_reg.flag)
      else $error("flag not cleared while disabled");

   // Main scenarios
   COV_BURST: cover property (@(posedge ref_clk_in) $rose(st_reg.phase == IRPTM_DONE));
   COV_GAP: cover property (@(posedge ref_clk_in) st_reg.phase == IRPTM_GAP ##1
      st_reg.phase == IRPTM_ACTIVE);
   COV_LONG: cover property (@(posedge ref_clk_in) st_reg.ctrl[`IRPTM_BIT_LONG] && timer_end
      && st_reg.phase == IRPTM_ACTIVE);
   COV_PWM: cover property (@(posedge ref_clk_in) st_reg.ctrl[`IRPTM_BIT_PWM] && timer_end
      && st_reg.phase == IRPTM_GAP);
   COV_ABORT: cover property (@(posedge ref_clk_in) st_reg.phase == IRPTM_ACTIVE ##1
      st_reg.phase == IRPTM_IDLE);
endmodule
`default_nettype wire

// >>> bench/irptm_led_model.sv
// Infrared LED model that counts lit cycles and light flashes
`timescale 1ns/100ps
`default_nettype none
module irptm_led_model (
   input  wire logic        ref_clk_in,  // Oscillator clock
   input  wire logic        clr_in,      // Clear the counters
   input  wire logic        drive_in,    // Pin level, low lights LED
   output logic      [15:0] lit_out,     // Cycles lit
   output logic      [15:0] flash_out    // Lit episodes
);
   logic prev_reg;
   // Sampled on the clock, so carrier gaps show as separate flashes
   always_ff @(posedge ref_clk_in) begin
      prev_reg <= drive_in;
      if (clr_in) begin
         lit_out   <= 16'h0000;
         flash_out <= 16'h0000;
         prev_reg  <= 1'b1;
      end else begin
         if (!drive_in) lit_out <= lit_out + 16'h0001;
         if (prev_reg && !drive_in) flash_out <= flash_out + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// >>> bench/ir_pulse_train_modulator_test.sv
// Self-checking bench for the IR pulse train modulator
`timescale 1ns/100ps
`default_nettype none
module ir_pulse_train_modulator_test;
   logic clk = 1'b0, rst_n = 1'b0, page1 = 1'b1, wr = 1'b0, fclr = 1'b0, lclr = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00, rdata;
   logic        ir, irq;
   logic [15:0] lit, flash;
   int          n_fail = 0, tests_run = 0;
   // -------------------------------------------------------------
   // Clock, design and LED
   // -------------------------------------------------------------
   always #2.5 clk = ~clk;
   irptm_top uut (.ref_clk_in(clk), .rst_n_in(rst_n), .page1_in(page1), .addr_in(addr),
      .wr_in(wr), .wdata_in(wdata), .flag_clr_in(fclr), .rdata_out(rdata),
      .ir_drive_out(ir), .irq_out(irq));
   irptm_led_model led (.ref_clk_in(clk), .clr_in(lclr), .drive_in(ir),
      .lit_out(lit), .flash_out(flash));
   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks=%0d mismatches=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic read_reg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      step;
      check(rdata, exp);
   endtask
   task automatic pulse_clr(input logic with_led);
      @(posedge clk);
      fclr <= 1'b1;
      lclr <= with_led;
      @(posedge clk);
      fclr <= 1'b0;
      lclr <= 1'b0;
   endtask
   // Toggling the enable is the only way to arm a new burst
   task automatic restart(input logic [7:0] c);
      wr_reg(4'hD, 8'h00);
      pulse_clr(1'b1);
      wr_reg(4'hD, c);
   endtask
   task automatic run_len(input logic lvl, output int n);
      n = 0;
      while (ir === lvl && n < 1000) begin
         n++;
         step;
      end
   endtask
   task automatic load(input logic [7:0] c, a, h, input logic [15:0] n);
      restart(c);
      wr_reg(4'h9, a);
      wr_reg(4'hA, h);
      wr_reg(4'h7, n[15:8]);
      wr_reg(4'h6, n[7:0]);
      // Look just after the start edge so the first low run is counted whole
      #1;
   endtask
   // One burst, every low and high run measured
   task automatic burst(input logic [7:0] c, a, h, input logic [15:0] n, lo, np);
      int len;
      load(c, a, h, n);
      check(ir, 1'b0);
      for (int i = 0; i < np; i++) begin
         run_len(1'b0, len);
         check(len[15:0], lo);
         if (i < np - 1) begin
            run_len(1'b1, len);
            check(len[15:0], {8'h00, h});
         end
      end
      check(irq, 1'b1);
      repeat (4) step;
      check(ir, 1'b1);
      check(flash, np);
      check(lit, lo * np);
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_regs;
      check(ir, 1'b1);
      check(irq, 1'b0);
      read_reg(4'hD, 8'h00);
      wr_reg(4'h9, 8'h5A);
      wr_reg(4'hA, 8'hC3);
      read_reg(4'h9, 8'h5A);
      read_reg(4'hA, 8'hC3);
      @(posedge clk);
      page1 <= 1'b0;
      wr_reg(4'h9, 8'h33);
      read_reg(4'h9, 8'h00);
      @(posedge clk);
      page1 <= 1'b1;
      read_reg(4'h9, 8'h5A);
   endtask
   task automatic t_flag;
      pulse_clr(1'b0);
      step;
      check(irq, 1'b1);
      read_reg(4'hE, 8'h03);
      wr_reg(4'h6, 8'h03);
      repeat (3) step;
      check(ir, 1'b1);
      wr_reg(4'hD, 8'h00);
      pulse_clr(1'b0);
      step;
      check(irq, 1'b0);
      read_reg(4'hE, 8'h00);
   endtask
   task automatic t_modes;
      int len;
      load(8'h08, 8'h14, 8'h04, 16'h0005);
      repeat (5) step;
      wr_reg(4'hD, 8'h00);
      repeat (2) step;
      check(ir, 1'b1);
      check(irq, 1'b0);
      load(8'h09, 8'h02, 8'h03, 16'h0001);
      for (int i = 0; i < 3; i++) begin
         run_len(1'b0, len);
         check(len[15:0], 16'h0002);
         run_len(1'b1, len);
         check(len[15:0], 16'h0003);
      end
      check(irq, 1'b0);
      load(8'h2C, 8'h08, 8'h08, 16'h0001);
      repeat (30) step;
      check(lit, 16'h0004);
      check(irq, 1'b1);
   endtask
   // -------------------------------------------------------------
   // Main sequence and watchdog
   // -------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      wr_reg(4'h8, 8'h10);
      burst(8'h08, 8'h03, 8'h04, 16'h0003, 16'h0003, 16'h0003);
      t_flag;
      burst(8'h08, 8'h01, 8'h01, 16'h0100, 16'h0001, 16'h0100);
      burst(8'h0A, 8'h03, 8'h04, 16'h0002, 16'h0006, 16'h0001);
      wr_reg(4'h8, 8'h00);
      burst(8'h08, 8'h02, 8'h02, 16'h0102, 16'h0002, 16'h0002);
      t_modes;
      results;
   end
   // Whole run is under a thousand cycles
   initial begin
      #100000;
      n_fail++;
      results;
   end
endmodule
`default_nettype wire
